/* File: rtl/pcm_subframe_sync_decom.v */
// minor-frame identification, format switching and word decommutation
//
// Notes on behaviour
// - identify minor frames by counter word, complemented sync alternation, or not at all
// - counter word placed by a bit count from frame start to its lsb
// - counter word arrives msb or lsb first; both orders use the one counter width
// - counter has programmable first and last values
// - search to check and check to lock need separate hit counts
// - lock to check and check to search need separate miss counts
// - with format change on, identifier word matched against patterns selects format
// - format changes only on minor-frame boundaries; sender keeps bit sync
// - one words-per-frame count, set for format 0, serves every format
// - per-word widths default to common width; sum below bits per frame
// - data goes out in blocks of a whole number of frames, at least one
// - bit numbering puts msb and lsb at bit 0, bit 1 or bit n
// - embedded stream occupies fixed word positions in every minor frame
// - promotion count is number of found patterns before advancing
// - demotion count is number of missed patterns before falling
`include "sfsync_map.vh"

module pcm_subframe_sync_decom (
    // clock and reset
    input  wire                            mclk,
    input  wire                            rst_b,
    // pcm pins from main frame sync
    input  wire                            pcm_clk_in,
    input  wire                            pcm_data_in,
    input  wire                            frame_start_in,
    input  wire                            sync_inverted_in,
    // identification setup
    input  wire [1:0]                      id_method,
    input  wire [15:0]                     ctr_bit_pos,
    input  wire                            ctr_lsb_first,
    input  wire [4:0]                      ctr_width,
    input  wire [`SF_CTR_W-1:0]            ctr_first,
    input  wire [`SF_CTR_W-1:0]            ctr_last,
    // sync criteria
    input  wire [`SF_CNT_W-1:0]            n_search_check,
    input  wire [`SF_CNT_W-1:0]            n_check_lock,
    input  wire [`SF_CNT_W-1:0]            n_lock_check,
    input  wire [`SF_CNT_W-1:0]            n_check_search,
    // format change setup
    input  wire                            fmt_change_en,
    input  wire [`SF_IDX_W-1:0]            fmt_word_index,
    input  wire [`SF_FMT_W-1:0]            fmt_count_m1,
    input  wire [`SF_FMT_N*`SF_PAT_W-1:0]  fmt_patterns,
    // frame layout
    input  wire [`SF_IDX_W-1:0]            words_per_frame,
    input  wire [15:0]                     bits_per_frame,
    input  wire [5:0]                      common_width,
    input  wire                            wtab_we,
    input  wire [`SF_IDX_W-1:0]            wtab_addr,
    input  wire [5:0]                      wtab_data,
    input  wire                            index_base,
    input  wire                            msb_at_top,
    input  wire [7:0]                      block_frames,
    // embedded stream location
    input  wire [`SF_IDX_W-1:0]            emb_start_word,
    input  wire [`SF_IDX_W-1:0]            emb_end_word,
    // decommutated words
    output reg                             word_valid_r,
    output reg  [`SF_WORD_MAX:0]           word_data_r,
    output reg  [`SF_IDX_W-1:0]            word_index_r,
    output reg  [`SF_FMT_W-1:0]            word_fmt_r,
    output reg                             word_emb_r,
    output reg                             frame_end_r,
    output reg                             block_end_r,
    // status
    output reg  [1:0]                      sf_state_r,
    output reg  [`SF_FMT_W-1:0]            fmt_cur_r,
    output reg  [`SF_CTR_W-1:0]            sf_count_r,
    output reg                             cfg_err_r
);

    // pin synchronisers: stage 0 feeds stage 1 only
    reg [2:0] clk_q_r;
    reg [2:0] dat_q_r;
    reg [2:0] fs_q_r;
    reg [2:0] inv_q_r;
    reg       clk_st_r;

    wire clk_agree = (clk_q_r[1] == clk_q_r[2]);
    wire bit_ev    = clk_agree && clk_q_r[2] && !clk_st_r;
    wire first     = bit_ev && fs_q_r[2];

    always @(posedge mclk) begin
        if (!rst_b) begin
            clk_q_r  <= 3'h0;
            dat_q_r  <= 3'h0;
            fs_q_r   <= 3'h0;
            inv_q_r  <= 3'h0;
            clk_st_r <= 1'b0;
        end else begin
            clk_q_r <= {clk_q_r[1:0], pcm_clk_in};
            dat_q_r <= {dat_q_r[1:0], pcm_data_in};
            fs_q_r  <= {fs_q_r[1:0], frame_start_in};
            inv_q_r <= {inv_q_r[1:0], sync_inverted_in};
            if (clk_agree) begin
                clk_st_r <= clk_q_r[2];
            end
        end
    end

    // counter word capture
    reg  [15:0]           bitpos_r;
    reg  [`SF_CTR_W-1:0]  ctr_sh_r;
    reg  [15:0]           pos_nxt;
    reg  [`SF_CTR_W-1:0]  sh_nxt;
    reg  [`SF_CTR_W-1:0]  ctr_mask;
    reg  [4:0]            ctr_w_eff;
    reg  [`SF_CTR_W-1:0]  ctr_seen;
    reg                   ctr_take;

    function [`SF_CTR_W-1:0] rev16;
        input [`SF_CTR_W-1:0] v;
        integer k;
        begin
            for (k = 0; k < `SF_CTR_W; k = k + 1) begin
                rev16[k] = v[`SF_CTR_W-1-k];
            end
        end
    endfunction

    function [`SF_CTR_W-1:0] next_ctr;
        input [`SF_CTR_W-1:0] v;
        input [`SF_CTR_W-1:0] lo;
        input [`SF_CTR_W-1:0] hi;
        begin
            next_ctr = (v == hi) ? lo : v + 16'h0001;
        end
    endfunction

    always @* begin
        pos_nxt  = first ? 16'h0001 : ((bitpos_r == 16'hffff) ? bitpos_r : bitpos_r + 16'h0001);
        sh_nxt   = {ctr_sh_r[`SF_CTR_W-2:0], dat_q_r[2]};
        // a width of zero or sixteen and up means the full sixteen bits
        ctr_w_eff = (ctr_width == 5'h00 || ctr_width >= 5'h10) ? 5'h10 : ctr_width;
        ctr_mask  = (ctr_w_eff == 5'h10) ? 16'hffff : ((16'h0001 << ctr_w_eff) - 16'h0001);
        if (ctr_lsb_first) begin
            // lsb arrives at the counted position, the word runs on for its width
            ctr_take = bit_ev &&
                       (pos_nxt == ctr_bit_pos + {11'h000, ctr_w_eff} - 16'h0001);
            ctr_seen = (rev16(sh_nxt) >> (5'h10 - ctr_w_eff)) & ctr_mask;
        end else begin
            ctr_take = bit_ev && (pos_nxt == ctr_bit_pos);
            ctr_seen = sh_nxt & ctr_mask;
        end
    end

    // per-frame qualifying events for the state keeper
    reg                   hit_r;
    reg                   miss_r;
    reg  [`SF_CTR_W-1:0]  expect_r;
    reg                   inv_prev_r;
    wire [1:0]            st;

    always @(posedge mclk) begin
        if (!rst_b) begin
            bitpos_r   <= 16'h0000;
            ctr_sh_r   <= `SF_CTR_RST;
            expect_r   <= `SF_CTR_RST;
            sf_count_r <= `SF_CTR_RST;
            inv_prev_r <= 1'b0;
            hit_r      <= 1'b0;
            miss_r     <= 1'b0;
        end else begin
            hit_r  <= 1'b0;
            miss_r <= 1'b0;
            if (bit_ev) begin
                bitpos_r <= pos_nxt;
                ctr_sh_r <= sh_nxt;
            end
            case (id_method)
                `SF_ID_COUNTER: begin
                    if (ctr_take) begin
                        sf_count_r <= ctr_seen;
                        expect_r   <= next_ctr(ctr_seen, ctr_first, ctr_last);
                        if (st == `SF_ST_SEARCH) begin
                            // any value inside the programmed range counts as a search hit
                            if (ctr_seen >= ctr_first && ctr_seen <= ctr_last) begin
                                hit_r <= 1'b1;
                            end
                        end else if (ctr_seen == expect_r) begin
                            hit_r <= 1'b1;
                        end else begin
                            miss_r <= 1'b1;
                        end
                    end
                end
                `SF_ID_ALT: begin
                    if (first) begin
                        inv_prev_r <= inv_q_r[2];
                        // outside search the pattern sense must flip on every minor frame
                        if (st == `SF_ST_SEARCH || inv_q_r[2] != inv_prev_r) begin
                            hit_r <= 1'b1;
                        end else begin
                            miss_r <= 1'b1;
                        end
                        sf_count_r <= inv_q_r[2] ? 16'h0001 : 16'h0000;
                    end
                end
                `SF_ID_NONE: begin
                    if (first) begin
                        hit_r <= 1'b1;
                    end
                end
                default: begin
                    hit_r <= 1'b0;
                end
            endcase
        end
    end

    sf_sync_fsm u_fsm (
        .mclk           (mclk),
        .rst_b          (rst_b),
        .hit            (hit_r),
        .miss           (miss_r),
        .n_search_check (n_search_check),
        .n_check_lock   (n_check_lock),
        .n_lock_check   (n_lock_check),
        .n_check_search (n_check_search),
        .state_r        (st)
    );

    // word assembly
    wire                   wv;
    wire [`SF_WORD_MAX:0]  wd;
    wire [`SF_IDX_W-1:0]   wi;
    wire                   wlast;
    wire [15:0]            used;

    sf_word_assembler u_asm (
        .mclk            (mclk),
        .rst_b           (rst_b),
        .bit_ev          (bit_ev),
        .bit_val         (dat_q_r[2]),
        .first           (first),
        .words_per_frame (words_per_frame),
        .common_width    (common_width),
        .wtab_we         (wtab_we),
        .wtab_addr       (wtab_addr),
        .wtab_data       (wtab_data),
        .index_base      (index_base),
        .msb_at_top      (msb_at_top),
        .wv_r            (wv),
        .wd_r            (wd),
        .wi_r            (wi),
        .last_r          (wlast),
        .used_r          (used)
    );

    // format identifier match, held until the next minor-frame start
    reg                   fmt_pend_v_r;
    reg [`SF_FMT_W-1:0]   fmt_pend_r;
    reg                   fmt_hit;
    reg [`SF_FMT_W-1:0]   fmt_sel;
    integer               f;

    always @* begin
        fmt_hit = 1'b0;
        fmt_sel = `SF_FMT_RST;
        for (f = `SF_FMT_N - 1; f >= 0; f = f - 1) begin
            if (f <= fmt_count_m1 &&
                wd[`SF_PAT_W-1:0] == fmt_patterns[f*`SF_PAT_W +: `SF_PAT_W]) begin
                fmt_hit = 1'b1;
                fmt_sel = f[`SF_FMT_W-1:0];
            end
        end
    end

    reg [7:0] blk_cnt_r;

    always @(posedge mclk) begin
        if (!rst_b) begin
            fmt_pend_v_r <= 1'b0;
            fmt_pend_r   <= `SF_FMT_RST;
            fmt_cur_r    <= `SF_FMT_RST;
            blk_cnt_r    <= 8'h00;
            word_valid_r <= 1'b0;
            word_data_r  <= {(`SF_WORD_MAX+1){1'b0}};
            word_index_r <= {`SF_IDX_W{1'b0}};
            word_fmt_r   <= `SF_FMT_RST;
            word_emb_r   <= 1'b0;
            frame_end_r  <= 1'b0;
            block_end_r  <= 1'b0;
            sf_state_r   <= `SF_ST_SEARCH;
            cfg_err_r    <= 1'b0;
        end else begin
            sf_state_r   <= st;
            word_valid_r <= wv;
            frame_end_r  <= wlast;
            block_end_r  <= 1'b0;
            if (wv) begin
                word_data_r  <= wd;
                word_index_r <= wi;
                word_fmt_r   <= fmt_cur_r;
                word_emb_r   <= (wi >= emb_start_word) && (wi <= emb_end_word);
            end
            if (fmt_change_en && wv && wi == fmt_word_index && fmt_hit) begin
                fmt_pend_v_r <= 1'b1;
                fmt_pend_r   <= fmt_sel;
            end
            // switching mid-frame would mislabel the rest of the frame
            if (first && fmt_pend_v_r) begin
                fmt_cur_r    <= fmt_pend_r;
                fmt_pend_v_r <= 1'b0;
            end
            if (!fmt_change_en) begin
                fmt_cur_r    <= `SF_FMT_RST;
                fmt_pend_v_r <= 1'b0;
            end
            if (wlast) begin
                cfg_err_r <= (used >= bits_per_frame);
                // a block size of zero is treated as one frame
                if (blk_cnt_r + 8'h01 >= block_frames) begin
                    block_end_r <= 1'b1;
                    blk_cnt_r   <= 8'h00;
                end else begin
                    blk_cnt_r <= blk_cnt_r + 8'h01;
                end
            end
        end
    end

endmodule

/* File: rtl/sfsync_map.vh */
// constants shared by the minor-frame sync and decommutation stage
`ifndef SFSYNC_MAP_VH
`define SFSYNC_MAP_VH

// subframe sync states
`define SF_ST_SEARCH   2'h0
`define SF_ST_CHECK    2'h1
`define SF_ST_LOCK     2'h2

// minor-frame identification methods
`define SF_ID_COUNTER  2'h0
`define SF_ID_ALT      2'h1
`define SF_ID_NONE     2'h2

// widths
`define SF_CTR_W       16
`define SF_WORD_MAX    32
`define SF_IDX_W       10
`define SF_TAB_DEPTH   1024
`define SF_FMT_N       8
`define SF_FMT_W       3
`define SF_PAT_W       16
`define SF_CNT_W       8

// reset values
`define SF_FMT_RST     3'h0
`define SF_CTR_RST     16'h0000

`endif

/* File: rtl/sf_sync_fsm.v */
// search / check / lock state keeper with promote and demote counts
`include "sfsync_map.vh"

module sf_sync_fsm (
    // clock and reset
    input  wire                    mclk,
    input  wire                    rst_b,
    // per-frame qualifying events
    input  wire                    hit,
    input  wire                    miss,
    // criteria
    input  wire [`SF_CNT_W-1:0]    n_search_check,
    input  wire [`SF_CNT_W-1:0]    n_check_lock,
    input  wire [`SF_CNT_W-1:0]    n_lock_check,
    input  wire [`SF_CNT_W-1:0]    n_check_search,
    // state
    output reg  [1:0]              state_r
);

    reg [`SF_CNT_W-1:0] hits_r;
    reg [`SF_CNT_W-1:0] misses_r;

    // a count of zero moves on the first qualifying event
    function reached;
        input [`SF_CNT_W-1:0] cnt;
        input [`SF_CNT_W-1:0] lim;
        begin
            reached = (cnt >= lim);
        end
    endfunction

    always @(posedge mclk) begin
        if (!rst_b) begin
            state_r  <= `SF_ST_SEARCH;
            hits_r   <= {`SF_CNT_W{1'b0}};
            misses_r <= {`SF_CNT_W{1'b0}};
        end else begin
            case (state_r)
                `SF_ST_SEARCH: begin
                    misses_r <= {`SF_CNT_W{1'b0}};
                    if (hit) begin
                        if (reached(hits_r, n_search_check)) begin
                            state_r <= `SF_ST_CHECK;
                            hits_r  <= {`SF_CNT_W{1'b0}};
                        end else begin
                            hits_r <= hits_r + 8'h01;
                        end
                    end
                end
                `SF_ST_CHECK: begin
                    if (hit) begin
                        misses_r <= {`SF_CNT_W{1'b0}};
                        if (reached(hits_r, n_check_lock)) begin
                            state_r <= `SF_ST_LOCK;
                            hits_r  <= {`SF_CNT_W{1'b0}};
                        end else begin
                            hits_r <= hits_r + 8'h01;
                        end
                    end else if (miss) begin
                        hits_r <= {`SF_CNT_W{1'b0}};
                        if (reached(misses_r, n_check_search)) begin
                            state_r  <= `SF_ST_SEARCH;
                            misses_r <= {`SF_CNT_W{1'b0}};
                        end else begin
                            misses_r <= misses_r + 8'h01;
                        end
                    end
                end
                `SF_ST_LOCK: begin
                    hits_r <= {`SF_CNT_W{1'b0}};
                    if (hit) begin
                        misses_r <= {`SF_CNT_W{1'b0}};
                    end else if (miss) begin
                        if (reached(misses_r, n_lock_check)) begin
                            state_r  <= `SF_ST_CHECK;
                            misses_r <= {`SF_CNT_W{1'b0}};
                        end else begin
                            misses_r <= misses_r + 8'h01;
                        end
                    end
                end
                default: begin
                    state_r <= `SF_ST_SEARCH;
                end
            endcase
        end
    end

endmodule

/* File: rtl/sf_word_assembler.v */
// cuts the minor frame into words of per-word width and applies bit indexing
`include "sfsync_map.vh"

module sf_word_assembler (
    // clock and reset
    input  wire                    mclk,
    input  wire                    rst_b,
    // bit stream, one event per pcm bit
    input  wire                    bit_ev,
    input  wire                    bit_val,
    input  wire                    first,
    // frame layout
    input  wire [`SF_IDX_W-1:0]    words_per_frame,
    input  wire [5:0]              common_width,
    input  wire                    wtab_we,
    input  wire [`SF_IDX_W-1:0]    wtab_addr,
    input  wire [5:0]              wtab_data,
    input  wire                    index_base,
    input  wire                    msb_at_top,
    // words out
    output reg                     wv_r,
    output reg  [`SF_WORD_MAX:0]   wd_r,
    output reg  [`SF_IDX_W-1:0]    wi_r,
    output reg                     last_r,
    output reg  [15:0]             used_r
);

    reg [5:0]                wtab [0:`SF_TAB_DEPTH-1];
    reg [`SF_TAB_DEPTH-1:0]  tab_vld_r;
    reg                      active_r;
    reg [`SF_IDX_W-1:0]      widx_r;
    reg [5:0]                bcnt_r;
    reg [`SF_WORD_MAX-1:0]   sh_r;
    reg [15:0]               acc_r;

    reg [`SF_IDX_W-1:0]      idx;
    reg [5:0]                w;
    reg [5:0]                b;
    reg [`SF_WORD_MAX-1:0]   sh_nxt;
    reg [`SF_WORD_MAX-1:0]   ordered;
    reg [`SF_WORD_MAX-1:0]   wmask;

    function [`SF_WORD_MAX-1:0] rev32;
        input [`SF_WORD_MAX-1:0] v;
        integer k;
        begin
            for (k = 0; k < `SF_WORD_MAX; k = k + 1) begin
                rev32[k] = v[`SF_WORD_MAX-1-k];
            end
        end
    endfunction

    always @(posedge mclk) begin
        if (wtab_we) begin
            wtab[wtab_addr] <= wtab_data;
        end
    end

    always @* begin
        idx    = first ? {`SF_IDX_W{1'b0}} : widx_r;
        // an unwritten or zero entry takes the common width
        w      = (tab_vld_r[idx] && wtab[idx] != 6'h00) ? wtab[idx] : common_width;
        b      = first ? 6'h00 : bcnt_r;
        sh_nxt = first ? {{(`SF_WORD_MAX-1){1'b0}}, bit_val} : {sh_r[`SF_WORD_MAX-2:0], bit_val};
        // the shifter still holds older words above this width, so mask them off
        wmask   = {`SF_WORD_MAX{1'b1}} >> (6'h20 - w);
        // msb at the top keeps transmit order, otherwise the msb lands on bit 0
        ordered = msb_at_top ? (sh_nxt & wmask) : (rev32(sh_nxt) >> (6'h20 - w));
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            tab_vld_r <= {`SF_TAB_DEPTH{1'b0}};
            active_r  <= 1'b0;
            widx_r    <= {`SF_IDX_W{1'b0}};
            bcnt_r    <= 6'h00;
            sh_r      <= {`SF_WORD_MAX{1'b0}};
            acc_r     <= 16'h0000;
            wv_r      <= 1'b0;
            wd_r      <= {(`SF_WORD_MAX+1){1'b0}};
            wi_r      <= {`SF_IDX_W{1'b0}};
            last_r    <= 1'b0;
            used_r    <= 16'h0000;
        end else begin
            wv_r   <= 1'b0;
            last_r <= 1'b0;
            if (wtab_we) begin
                tab_vld_r[wtab_addr] <= 1'b1;
            end
            if (bit_ev && (active_r || first)) begin
                sh_r <= sh_nxt;
                if (first) begin
                    active_r <= 1'b1;
                end
                if (b + 6'h01 >= w) begin
                    wv_r   <= 1'b1;
                    wd_r   <= index_base ? {ordered, 1'b0} : {1'b0, ordered};
                    wi_r   <= idx;
                    bcnt_r <= 6'h00;
                    widx_r <= idx + 10'h001;
                    if (idx + 10'h001 >= words_per_frame) begin
                        active_r <= 1'b0;
                        last_r   <= 1'b1;
                        used_r   <= (first ? 16'h0000 : acc_r) + {10'h000, w};
                        acc_r    <= 16'h0000;
                    end else begin
                        acc_r <= (first ? 16'h0000 : acc_r) + {10'h000, w};
                    end
                end else begin
                    bcnt_r <= b + 6'h01;
                    widx_r <= idx;
                    if (first) begin
                        acc_r <= 16'h0000;
                    end
                end
            end
        end
    end

endmodule

/* File: tb/sf_decom_properties.sv */
// checker for the decommutated word stream and subframe sync status
`include "sfsync_map.vh"
module sf_decom_properties (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst_b,
    // layout setup
    input wire logic [`SF_IDX_W-1:0] words_per_frame,
    input wire logic [`SF_IDX_W-1:0] emb_start_word,
    input wire logic [`SF_IDX_W-1:0] emb_end_word,
    input wire logic [`SF_FMT_W-1:0] fmt_count_m1,
    // outputs watched
    input wire logic                 word_valid_r,
    input wire logic [`SF_IDX_W-1:0] word_index_r,
    input wire logic [`SF_FMT_W-1:0] word_fmt_r,
    input wire logic                 word_emb_r,
    input wire logic                 frame_end_r,
    input wire logic                 block_end_r,
    input wire logic [1:0]           sf_state_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_word_pulse: assert property (word_valid_r |=> !word_valid_r)
        else $error("word strobe held");
    a_frame_last: assert property (frame_end_r |-> word_valid_r
        && word_index_r == words_per_frame - 10'h001) else $error("frame end misplaced");
    a_block_whole: assert property (block_end_r |-> frame_end_r)
        else $error("block end off frame end");
    a_index_range: assert property (word_valid_r |-> word_index_r < words_per_frame)
        else $error("word index beyond frame");
    a_emb_flag: assert property (word_valid_r |-> word_emb_r ==
        (word_index_r >= emb_start_word && word_index_r <= emb_end_word))
        else $error("embedded flag wrong");
    a_fmt_range: assert property (word_valid_r |-> word_fmt_r <= fmt_count_m1)
        else $error("format out of range");
    a_search_step: assert property (sf_state_r == `SF_ST_SEARCH
        |=> sf_state_r != `SF_ST_LOCK) else $error("search jumped to lock");
    a_lock_step: assert property (sf_state_r == `SF_ST_LOCK
        |=> sf_state_r != `SF_ST_SEARCH) else $error("lock fell to search");
endmodule
bind pcm_subframe_sync_decom sf_decom_properties chk (.*);

/* File: tb/pcm_src.sv */
// encoder model: counter word, data word, then alternating fill bits
module pcm_src (
    input wire logic mclk,
    output logic     pcm_clk_in,
    output logic     pcm_data_in,
    output logic     frame_start_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pcm_clk_in = 1'b0;
        pcm_data_in = 1'b0;
        frame_start_in = 1'b0;
    end
    // data set with the clock low and held 8 mclk around the rise
    task automatic put_bit(input logic b, input logic fs);
        @(posedge mclk);
        #1 pcm_clk_in = 1'b0;
        pcm_data_in = b;
        frame_start_in = fs;
        repeat (4) @(posedge mclk);
        #1 pcm_clk_in = 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    // fill bits keep the bit clock going, never a dead period
    task automatic send_frame(input logic [7:0] c, input logic [7:0] w);
        for (int i = 0; i < 20; i++) begin
            put_bit(i < 8 ? c[7-i] : (i < 16 ? w[15-i] : i[0]), i == 0);
        end
    endtask
endmodule

/* File: tb/test_pcm_subframe_sync_decom.sv */
// bench: counter-word sync walk, word data and format switching
`include "sfsync_map.vh"
module test_pcm_subframe_sync_decom;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_b = 1'b0, sync_inverted_in = 1'b0, ctr_lsb_first = 1'b0;
    logic wtab_we = 1'b0, index_base = 1'b0, msb_at_top = 1'b1, fmt_change_en = 1'b1;
    logic [1:0] id_method = `SF_ID_COUNTER;
    logic [15:0] ctr_bit_pos = 16'h0008, bits_per_frame = 16'h0014;
    logic [15:0] ctr_first = 16'h0000, ctr_last = 16'h0003;
    logic [4:0] ctr_width = 5'h08;
    logic [7:0] n_search_check = 8'h00, n_check_lock = 8'h01, block_frames = 8'h02;
    logic [7:0] n_lock_check = 8'h00, n_check_search = 8'h00, exp_w, exp_c;
    logic [9:0] fmt_word_index = 10'h001, words_per_frame = 10'h002, wtab_addr = 10'h000;
    logic [9:0] emb_start_word = 10'h001, emb_end_word = 10'h001;
    logic [2:0] fmt_count_m1 = 3'h1;
    logic [127:0] fmt_patterns = {96'h0, 16'h00a5, 16'hffff};
    logic [5:0] common_width = 6'h08, wtab_data = 6'h00;
    logic pcm_clk_in, pcm_data_in, frame_start_in;
    logic word_valid_r, word_emb_r, frame_end_r, block_end_r, cfg_err_r;
    logic [32:0] word_data_r;
    logic [9:0] word_index_r;
    logic [2:0] word_fmt_r, fmt_cur_r;
    logic [1:0] sf_state_r;
    logic [15:0] sf_count_r;
    int n_fail = 0, compares = 0, cyc = 0, n_blk = 0;
    pcm_subframe_sync_decom dut (.*);
    pcm_src src (.mclk, .pcm_clk_in, .pcm_data_in, .frame_start_in);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic frame(input logic [7:0] c, input logic [7:0] w, input logic [1:0] st);
        exp_w = w;
        exp_c = c;
        src.send_frame(c, w);
        chk(sf_state_r, st);
    endtask
    // counter word and second word of each frame must come out as sent
    always @(posedge mclk) begin
        if (word_valid_r === 1'b1 && word_index_r === 10'h001) chk(word_data_r, {25'h0, exp_w});
        if (word_valid_r === 1'b1 && word_index_r === 10'h000) chk(word_data_r, {25'h0, exp_c});
    end
    // hang guard, about twice the expected run
    always @(posedge mclk) begin
        cyc++;
        if (block_end_r === 1'b1) n_blk++;
        if (cyc == 4000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b1;
        chk(sf_state_r, `SF_ST_SEARCH);
        frame(8'h00, 8'h3c, `SF_ST_CHECK);
        frame(8'h01, 8'h3c, `SF_ST_CHECK);
        frame(8'h02, 8'h3c, `SF_ST_LOCK);
        frame(8'h03, 8'h3c, `SF_ST_LOCK);
        frame(8'h00, 8'h3c, `SF_ST_LOCK);
        frame(8'h02, 8'h3c, `SF_ST_CHECK);
        frame(8'h00, 8'h3c, `SF_ST_SEARCH);
        frame(8'h01, 8'ha5, `SF_ST_CHECK);
        chk(fmt_cur_r, 3'h0);
        frame(8'h02, 8'h3c, `SF_ST_CHECK);
        chk(fmt_cur_r, 3'h1);
        chk(word_fmt_r, 3'h1);
        #1 fmt_change_en = 1'b0;
        frame(8'h03, 8'h3c, `SF_ST_LOCK);
        chk(fmt_cur_r, 3'h0);
        chk(sf_count_r, 16'h0003);
        chk(cfg_err_r, 1'b0);
        #1 bits_per_frame = 16'h0010;
        frame(8'h00, 8'h3c, `SF_ST_LOCK);
        chk(cfg_err_r, 1'b1);
        #1 id_method = `SF_ID_ALT;
        sync_inverted_in = 1'b1;
        frame(8'h01, 8'h3c, `SF_ST_LOCK);
        chk(sf_count_r, 16'h0001);
        frame(8'h02, 8'h3c, `SF_ST_CHECK);
        chk(n_blk, 6);
        tally_and_finish;
    end
endmodule
